// File: dv/pbc_pad_model.sv
/*
  Pad model for one 8-bit port: resolves each pin from the mux pad controls.
  Assumes an external driver per pin, given by enable and value from the bench.
*/
`timescale 1ns/1ns
module pbc_pad_model
  import pbc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire pbc_pkg::pbc_pad_s pad,
  input  wire logic [7:0]        extEn,
  input  wire logic [7:0]        extVal,
  output logic [7:0]             padIn
);
  logic floatReg = 1'b0;
  // Undriven pins without a pull-up wander every cycle, so no test leans on a stale level
  always @(posedge core_clk) begin
    floatReg <= ~floatReg;
  end
  assign padIn = (pad.outEnable & pad.outValue) | (~pad.outEnable & extEn & extVal)
               | (~pad.outEnable & ~extEn & (pad.pullupOn | {8{floatReg}}));
endmodule

// File: dv/pbc_pin_override_bench.sv
/*
  Self-checking bench for pbc_pin_override with pad models on both ports.
  Assumes a 100 MHz core clock; inputs change at the falling edge or up to 2 ns after it.
*/
`timescale 1ns/1ns
module pbc_pin_override_bench;
  import pbc_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst_n = 1'b0;
  pbc_portregs_s portBRegs, portCRegs;
  logic global_pullup_disable, spi_enable_bit, spi_master_select, spiClockOut, spiMasterOut, spiSlaveOut;
  logic usart_sync_select, usartClockOut, timer0CompareEnable, timer0_compare_out, extInt2Enable;
  logic timer2_async_enable, test_port_enable, instr_reg_shifting, data_reg_shifting, testDataOut;
  logic two_wire_enable, sdaOut, sclOut, spiMasterIn, spiSlaveIn, ext_interrupt_two, timer1_count_in;
  logic usartClockIn, timer0_count_in, osc_pin_one, testDataIn, sdaFiltered;
  logic osc_pin_two, testModeSelect, testClock, sclFiltered, spiClockIn, spiSlaveSelect;
  logic [7:0] portBPadIn, portCPadIn, bEn, bVal, cEn, cVal, portBDigitalIn, portCDigitalIn;
  pbc_pad_s   portBPad, portCPad;
  logic [1:0] twoWireSlewEnable;
  int         n_mismatch = 0;
  int         checked = 0;
  int         k;
  always #5 core_clk = ~core_clk;
  pbc_pin_override uut (.core_clk, .rst_n, .portBRegs, .portCRegs, .global_pullup_disable, .spi_enable_bit,
    .spi_master_select, .spiClockOut, .spiMasterOut, .spiSlaveOut, .usart_sync_select, .usartClockOut,
    .timer0CompareEnable, .timer0_compare_out, .extInt2Enable, .timer2_async_enable, .test_port_enable,
    .instr_reg_shifting, .data_reg_shifting, .testDataOut, .two_wire_enable, .sdaOut, .sclOut, .portBPadIn,
    .portCPadIn, .portBPad, .portCPad, .twoWireSlewEnable, .portBDigitalIn, .portCDigitalIn, .spiClockIn,
    .spiMasterIn, .spiSlaveIn, .spiSlaveSelect, .ext_interrupt_two, .timer1_count_in, .usartClockIn,
    .timer0_count_in, .osc_pin_one, .osc_pin_two, .testDataIn, .testModeSelect, .testClock, .sdaFiltered,
    .sclFiltered);
  pbc_pad_model u_bPads (.core_clk, .pad(portBPad), .extEn(bEn), .extVal(bVal), .padIn(portBPadIn));
  pbc_pad_model u_cPads (.core_clk, .pad(portCPad), .extEn(cEn), .extVal(cVal), .padIn(portCPadIn));
  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task automatic tally_and_finish();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_plain();
    @(negedge core_clk);
    portBRegs = {8'ha5, 8'h0f};
    #1;
    chk(portBPad.outEnable, 8'h0f);
    chk(portBPad.outValue, 8'ha5);
    chk(portBPad.pullupOn, 8'ha0);
    chk(portBPad.inputEnable, 8'hff);
    global_pullup_disable = 1'b1;
    #1;
    chk(portBPad.pullupOn, 8'h00);
    @(negedge core_clk);
    global_pullup_disable = 1'b0;
  endtask
  task automatic t_spi();
    @(negedge core_clk);
    portBRegs = {8'h90, 8'hff};
    spi_enable_bit = 1'b1;
    spiSlaveOut = 1'b1;
    spiMasterOut = 1'b1;
    bEn = 8'hf0;
    bVal = 8'hf0;
    #1;
    chk(portBPad.outEnable, 8'h4f);
    chk(portBPad.pullupOn, 8'h90);
    chkb(portBPad.outValue[6], 1'b1);
    chkb(spiSlaveIn, 1'b1);
    chk({spiClockIn, spiSlaveSelect}, 8'h03);
    // Slave mode must span a clock edge for the checker to see it
    @(negedge core_clk);
    spi_master_select = 1'b1;
    spiClockOut = 1'b1;
    #1;
    chk(portBPad.outEnable, 8'hbf);
    chkb(portBPad.outValue[7], 1'b1);
    chkb(portBPad.outValue[5], 1'b1);
    chkb(spiMasterIn, 1'b1);
    spi_enable_bit = 1'b0;
    spi_master_select = 1'b0;
  endtask
  task automatic t_lowb();
    @(negedge core_clk);
    portBRegs = {8'h00, 8'h09};
    timer0CompareEnable = 1'b1;
    timer0_compare_out = 1'b1;
    usart_sync_select = 1'b1;
    usartClockOut = 1'b1;
    #1;
    chkb(portBPad.outValue[3], 1'b1);
    chkb(portBPad.outValue[0], 1'b1);
    chkb(portBPad.outEnable[0], 1'b1);
    usart_sync_select = 1'b0;
    #1;
    chkb(portBPad.outValue[0], 1'b0);
    portBRegs = {8'h00, 8'h00};
    extInt2Enable = 1'b1;
    bEn = 8'h07;
    bVal = 8'h07;
    #1;
    chkb(portBPad.outEnable[0], 1'b0);
    chk({ext_interrupt_two, timer1_count_in, usartClockIn, timer0_count_in}, 8'h0f);
    chk(portBDigitalIn & 8'h07, 8'h07);
  endtask
  task automatic t_test();
    @(negedge core_clk);
    rst_n = 1'b0;
    test_port_enable = 1'b1;
    global_pullup_disable = 1'b1;
    portCRegs = {8'h00, 8'hff};
    #1;
    chk(portCPad.pullupOn & 8'h2c, 8'h2c);
    chk(portCPad.outEnable & 8'h2c, 8'h00);
    chk(portCPad.inputEnable & 8'h3c, 8'h00);
    chkb(sdaFiltered, 1'b1);
    @(negedge core_clk);
    rst_n = 1'b1;
    instr_reg_shifting = 1'b1;
    testDataOut = 1'b1;
    cEn = 8'h2c;
    cVal = 8'h2c;
    #1;
    chk(portCPad.outEnable & 8'h10, 8'h10);
    chk(portCPad.outValue & 8'h10, 8'h10);
    chkb(testDataIn, 1'b1);
    chk({testModeSelect, testClock}, 8'h03);
    chk(portCDigitalIn & 8'h3c, 8'h00);
    // Let an edge pass out of reset so the test-port checks are armed
    @(negedge core_clk);
    instr_reg_shifting = 1'b0;
    #1;
    chk(portCPad.outEnable & 8'h10, 8'h00);
    test_port_enable = 1'b0;
    global_pullup_disable = 1'b0;
  endtask
  task automatic t_osc();
    @(negedge core_clk);
    timer2_async_enable = 1'b1;
    portCRegs = {8'hff, 8'h00};
    cEn = 8'hc0;
    cVal = 8'hc0;
    #1;
    chk((portCPad.pullupOn | portCPad.inputEnable) & 8'hc0, 8'h00);
    chk({osc_pin_two, osc_pin_one}, 8'h03);
    chk(portCDigitalIn & 8'hc0, 8'h00);
    portCRegs = {8'h00, 8'hff};
    #1;
    chk(portCPad.outEnable & 8'hc0, 8'h00);
    @(negedge core_clk);
    timer2_async_enable = 1'b0;
  endtask
  task automatic t_twi();
    @(negedge core_clk);
    portCRegs = {8'h02, 8'hff};
    two_wire_enable = 1'b1;
    sclOut = 1'b1;
    #1;
    chk(portCPad.outEnable & 8'h03, 8'h02);
    chk(portCPad.outValue & 8'h03, 8'h00);
    chk(portCPad.pullupOn & 8'h03, 8'h02);
    chk({6'h0, twoWireSlewEnable}, 8'h03);
    @(negedge core_clk);
    sdaOut = 1'b1;
    sclOut = 1'b0;
    #1;
    chk(portCPad.outEnable & 8'h03, 8'h01);
  endtask
  task automatic t_filt();
    @(negedge core_clk);
    sclOut = 1'b1;
    cEn = 8'h03;
    cVal = 8'h03;
    repeat (10) @(negedge core_clk);
    chkb(sdaFiltered, 1'b1);
    chkb(sclFiltered, 1'b1);
    // Longest pulse that must still be dropped: one cycle under the filter time
    cVal = 8'h00;
    repeat (4) @(negedge core_clk);
    cVal = 8'h03;
    repeat (10) @(negedge core_clk);
    chkb(sdaFiltered, 1'b1);
    cVal = 8'h00;
    k = 0;
    while (sdaFiltered !== 1'b0 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    chkb(k >= 5 && k <= 10, 1'b1);
    chkb(sclFiltered, 1'b0);
    if (k >= 12) begin
      tally_and_finish();
    end
  endtask
  initial begin
    {global_pullup_disable, spi_enable_bit, spi_master_select, spiClockOut, spiMasterOut, spiSlaveOut} = '0;
    {usart_sync_select, usartClockOut, timer0CompareEnable, timer0_compare_out, extInt2Enable} = '0;
    {timer2_async_enable, test_port_enable, instr_reg_shifting, data_reg_shifting, testDataOut} = '0;
    {two_wire_enable, sdaOut, sclOut, portBRegs, portCRegs, bEn, bVal, cEn, cVal} = '0;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_plain();
    t_spi();
    t_lowb();
    t_test();
    t_osc();
    t_twi();
    t_filt();
    tally_and_finish();
  end
endmodule
bind pbc_pin_override pbc_pin_override_monitor u_mon (.core_clk, .rst_n, .global_pullup_disable, .spi_enable_bit,
  .spi_master_select, .timer2_async_enable, .test_port_enable, .instr_reg_shifting, .data_reg_shifting,
  .testDataOut, .two_wire_enable, .sdaOut, .sclOut, .portCPadIn, .portBPad, .portCPad, .twoWireSlewEnable,
  .sdaFiltered);

// File: dv/pbc_pin_override_monitor.sv
/*
  Checker for the port B/C override mux, bound onto pbc_pin_override.
  Assumes one core clock domain and the active-low reset port.
*/
`timescale 1ns/1ns
module pbc_pin_override_monitor
  import pbc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              global_pullup_disable,
  input wire logic              spi_enable_bit,
  input wire logic              spi_master_select,
  input wire logic              timer2_async_enable,
  input wire logic              test_port_enable,
  input wire logic              instr_reg_shifting,
  input wire logic              data_reg_shifting,
  input wire logic              testDataOut,
  input wire logic              two_wire_enable,
  input wire logic              sdaOut,
  input wire logic              sclOut,
  input wire logic [7:0]        portCPadIn,
  input wire pbc_pkg::pbc_pad_s portBPad,
  input wire pbc_pkg::pbc_pad_s portCPad,
  input wire logic [1:0]        twoWireSlewEnable,
  input wire logic              sdaFiltered
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_tstPull; test_port_enable |-> (portCPad.pullupOn & 8'h2c) == 8'h2c; endproperty
  a_tstPull: assert property (p_tstPull) else $error("test pull-ups off");
  property p_tstHold; test_port_enable |-> ((portCPad.inputEnable & 8'h3c) | (portCPad.outEnable & 8'h2c)) == 8'h00;
  endproperty
  a_tstHold: assert property (p_tstHold) else $error("test pins not withheld");
  property p_tdo; test_port_enable |-> portCPad.outEnable[4] == (instr_reg_shifting | data_reg_shifting)
    && portCPad.outValue[4] == testDataOut; endproperty
  a_tdo: assert property (p_tdo) else $error("test data out wrong");
  property p_osc; timer2_async_enable |-> ((portCPad.pullupOn | portCPad.outEnable | portCPad.inputEnable) & 8'hc0) == 8'h00;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pins not released");
  property p_od; two_wire_enable |-> portCPad.outEnable[1:0] == ~{sdaOut, sclOut} && portCPad.outValue[1:0] == 2'h0;
  endproperty
  a_od: assert property (p_od) else $error("two-wire drive wrong");
  property p_slew; twoWireSlewEnable == {2{two_wire_enable}}; endproperty
  a_slew: assert property (p_slew) else $error("slew control wrong");
  property p_pud; global_pullup_disable && !test_port_enable |-> portBPad.pullupOn == 8'h00; endproperty
  a_pud: assert property (p_pud) else $error("pull-up while disabled");
  property p_slave; spi_enable_bit && !spi_master_select |-> !portBPad.outEnable[7] && !portBPad.outEnable[4];
  endproperty
  a_slave: assert property (p_slave) else $error("slave clock pin driven");
  property p_spike; $fell(sdaFiltered) |-> !$past(portCPadIn[1], 4) && !$past(portCPadIn[1], 5); endproperty
  a_spike: assert property (p_spike) else $error("short pulse passed filter");
  c_tdo: cover property (test_port_enable && instr_reg_shifting);
  c_twi: cover property (two_wire_enable && !sdaOut);
  c_fall: cover property ($fell(sdaFiltered));
endmodule

// File: src/pbc_pin_override.sv
/*
  Pin override multiplexer for ports B and C with two-wire spike filters.
  Assumes port registers, peripherals and pads on the same core clock;
  the two-wire pad inputs are asynchronous and synchronised here.
*/
`timescale 1ns/1ns
module pbc_pin_override
  import pbc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire pbc_pkg::pbc_portregs_s portBRegs,
  input  wire pbc_pkg::pbc_portregs_s portCRegs,
  input  wire logic                   global_pullup_disable,
  input  wire logic                   spi_enable_bit,
  input  wire logic                   spi_master_select,
  input  wire logic                   spiClockOut,
  input  wire logic                   spiMasterOut,
  input  wire logic                   spiSlaveOut,
  input  wire logic                   usart_sync_select,
  input  wire logic                   usartClockOut,
  input  wire logic                   timer0CompareEnable,
  input  wire logic                   timer0_compare_out,
  input  wire logic                   extInt2Enable,
  input  wire logic                   timer2_async_enable,
  input  wire logic                   test_port_enable,
  input  wire logic                   instr_reg_shifting,
  input  wire logic                   data_reg_shifting,
  input  wire logic                   testDataOut,
  input  wire logic                   two_wire_enable,
  input  wire logic                   sdaOut,
  input  wire logic                   sclOut,
  input  wire logic [7:0]             portBPadIn,
  input  wire logic [7:0]             portCPadIn,
  output pbc_pkg::pbc_pad_s           portBPad,
  output pbc_pkg::pbc_pad_s           portCPad,
  output logic [1:0]                  twoWireSlewEnable,
  output logic [7:0]                  portBDigitalIn,
  output logic [7:0]                  portCDigitalIn,
  output logic                        spiClockIn,
  output logic                        spiMasterIn,
  output logic                        spiSlaveIn,
  output logic                        spiSlaveSelect,
  output logic                        ext_interrupt_two,
  output logic                        timer1_count_in,
  output logic                        usartClockIn,
  output logic                        timer0_count_in,
  output logic                        osc_pin_one,
  output logic                        osc_pin_two,
  output logic                        testDataIn,
  output logic                        testModeSelect,
  output logic                        testClock,
  output logic                        sdaFiltered,
  output logic                        sclFiltered
);
  import pbc_pkg::*;

  // ----------------------------------------
  // Reset release and state
  // ----------------------------------------
  pbc_state_s    state_reg;
  pbc_state_s    state_next;
  pbc_override_s ovB;
  pbc_override_s ovC;
  logic          rstSyncN;
  logic          spiOn;
  logic          spiMaster;
  logic          spiSlave;

  assign rstSyncN  = state_reg.rstSync[1];
  assign spiOn     = spi_enable_bit;
  assign spiMaster = spi_enable_bit & spi_master_select;
  assign spiSlave  = spi_enable_bit & ~spi_master_select;

  // One bit of the override mux, shared by every control of every pin
  function automatic logic pickBit(input logic en, input logic ov, input logic port);
    pickBit = en ? ov : port;
  endfunction

  // ----------------------------------------
  // Port B override table
  // ----------------------------------------
  always_comb begin
    ovB = '0;
    // SPI pins: pull-up follows port bit unless globally disabled
    for (int i = PB_SS; i <= PB_SCK; i++) begin
      ovB.pullupOverrideEnable[i]    = spiSlave;
      ovB.pullupOverrideValue[i]     = portBRegs.portOut[i] & ~global_pullup_disable;
      ovB.directionOverrideEnable[i] = spiSlave;
    end
    // Slave forces clock/MOSI/SS input; master forces MISO input
    ovB.pullupOverrideEnable[PB_MISO]    = spiMaster;
    ovB.directionOverrideEnable[PB_MISO] = spiMaster;
    ovB.directionOverrideEnable[PB_SCK]  = spiSlave;
    ovB.outputOverrideEnable[PB_SCK]     = spiMaster;
    ovB.outputOverrideValue[PB_SCK]      = spiClockOut;
    ovB.outputOverrideEnable[PB_MISO]    = spiSlave;
    ovB.outputOverrideValue[PB_MISO]     = spiSlaveOut;
    ovB.outputOverrideEnable[PB_MOSI]    = spiMaster;
    ovB.outputOverrideValue[PB_MOSI]     = spiMasterOut;
    ovB.outputOverrideEnable[PB_OC0]     = timer0CompareEnable;
    ovB.outputOverrideValue[PB_OC0]      = timer0_compare_out;
    ovB.inputEnableOverrideEnable[PB_EXT_INTERRUPT_TWO] = extInt2Enable;
    ovB.inputEnableOverrideValue[PB_EXT_INTERRUPT_TWO]  = 1'b1;
    // Direction stays with its bit; sync mode only swaps output value
    ovB.outputOverrideEnable[PB_XCK]     = usart_sync_select;
    ovB.outputOverrideValue[PB_XCK]      = usartClockOut;
  end

  // ----------------------------------------
  // Port C override table
  // ----------------------------------------
  always_comb begin
    ovC = '0;
    for (int i = PC_OSC1; i <= PC_OSC2; i++) begin
      ovC.pullupOverrideEnable[i]      = timer2_async_enable;
      ovC.directionOverrideEnable[i]   = timer2_async_enable;
      ovC.inputEnableOverrideEnable[i] = timer2_async_enable;
    end
    for (int i = PC_TCK; i <= PC_TDI; i++) begin
      ovC.pullupOverrideEnable[i]      = test_port_enable;
      ovC.directionOverrideEnable[i]   = test_port_enable;
      ovC.inputEnableOverrideEnable[i] = test_port_enable;
    end
    ovC.pullupOverrideValue[PC_TDI]      = 1'b1;
    ovC.pullupOverrideValue[PC_TMS]      = 1'b1;
    ovC.pullupOverrideValue[PC_TCK]      = 1'b1;
    ovC.directionOverrideValue[PC_TDO]   = instr_reg_shifting | data_reg_shifting;
    ovC.outputOverrideEnable[PC_TDO]     = test_port_enable;
    ovC.outputOverrideValue[PC_TDO]      = testDataOut;
    for (int i = PC_SCL; i <= PC_SDA; i++) begin
      ovC.pullupOverrideEnable[i]    = two_wire_enable;
      ovC.pullupOverrideValue[i]     = portCRegs.portOut[i] & ~global_pullup_disable;
      ovC.directionOverrideEnable[i] = two_wire_enable;
      ovC.outputOverrideEnable[i]    = two_wire_enable;
    end
    // Open drain: drive low only when the interface wants a zero
    ovC.directionOverrideValue[PC_SDA] = ~sdaOut;
    ovC.directionOverrideValue[PC_SCL] = ~sclOut;
  end

  // ----------------------------------------
  // Pad resolution
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      portBPad.outEnable[i]   = pickBit(ovB.directionOverrideEnable[i], ovB.directionOverrideValue[i],
                                        portBRegs.portDir[i]);
      portBPad.outValue[i]    = pickBit(ovB.outputOverrideEnable[i], ovB.outputOverrideValue[i],
                                        portBRegs.portOut[i]);
      portBPad.pullupOn[i]    = pickBit(ovB.pullupOverrideEnable[i], ovB.pullupOverrideValue[i],
                                        portBRegs.portOut[i] & ~portBRegs.portDir[i]
                                        & ~global_pullup_disable);
      portBPad.inputEnable[i] = pickBit(ovB.inputEnableOverrideEnable[i], ovB.inputEnableOverrideValue[i],
                                        1'b1);
      portCPad.outEnable[i]   = pickBit(ovC.directionOverrideEnable[i], ovC.directionOverrideValue[i],
                                        portCRegs.portDir[i]);
      portCPad.outValue[i]    = pickBit(ovC.outputOverrideEnable[i], ovC.outputOverrideValue[i],
                                        portCRegs.portOut[i]);
      portCPad.pullupOn[i]    = pickBit(ovC.pullupOverrideEnable[i], ovC.pullupOverrideValue[i],
                                        portCRegs.portOut[i] & ~portCRegs.portDir[i]
                                        & ~global_pullup_disable);
      portCPad.inputEnable[i] = pickBit(ovC.inputEnableOverrideEnable[i], ovC.inputEnableOverrideValue[i],
                                        1'b1);
    end
    // Test pull-ups are combinational from the enable, so reset cannot drop them
    portCPad.pullupOn[PC_TDI] = portCPad.pullupOn[PC_TDI] | test_port_enable;
    portCPad.pullupOn[PC_TMS] = portCPad.pullupOn[PC_TMS] | test_port_enable;
    portCPad.pullupOn[PC_TCK] = portCPad.pullupOn[PC_TCK] | test_port_enable;
  end

  assign twoWireSlewEnable = {2{two_wire_enable}};

  // ----------------------------------------
  // Peripheral input taps
  // ----------------------------------------
  // Pad inputs are masked by input enable; peripherals resync as needed
  assign portBDigitalIn    = portBPadIn & portBPad.inputEnable;
  assign portCDigitalIn    = portCPadIn & portCPad.inputEnable;
  assign spiClockIn        = portBDigitalIn[PB_SCK];
  assign spiMasterIn       = portBDigitalIn[PB_MISO];
  assign spiSlaveIn        = portBDigitalIn[PB_MOSI];
  assign spiSlaveSelect    = portBDigitalIn[PB_SS];
  assign ext_interrupt_two = portBDigitalIn[PB_EXT_INTERRUPT_TWO];
  assign timer1_count_in   = portBDigitalIn[PB_T1];
  assign usartClockIn      = portBDigitalIn[PB_XCK];
  assign timer0_count_in   = portBDigitalIn[PB_XCK];
  // Analog taps bypass the digital input gate
  assign osc_pin_one       = portCPadIn[PC_OSC1];
  assign osc_pin_two       = portCPadIn[PC_OSC2];
  // Raw test pins; the test port runs on its own clock and steps on mode select
  assign testDataIn        = portCPadIn[PC_TDI];
  assign testModeSelect    = portCPadIn[PC_TMS];
  assign testClock         = portCPadIn[PC_TCK];
  assign sdaFiltered       = state_reg.sdaFilt.level;
  assign sclFiltered       = state_reg.sclFilt.level;

  // ----------------------------------------
  // Spike filters and state update
  // ----------------------------------------
  // New level accepted only after it holds the full filter time
  function automatic pbc_filt_s filtStep(input pbc_filt_s f, input logic pad);
    pbc_filt_s n;
    n      = f;
    n.sync = {f.sync[0], pad};
    if (f.sync[1] == f.level) begin
      n.count = SPIKE_CNT_RST;
    end else if (f.count + 3'h1 >= SPIKE_CNT_MAX) begin
      n.level = f.sync[1];
      n.count = SPIKE_CNT_RST;
    end else begin
      n.count = f.count + 3'h1;
    end
    filtStep = n;
  endfunction

  always_comb begin
    state_next         = state_reg;
    state_next.rstSync = {state_reg.rstSync[0], 1'b1};
    if (!rstSyncN) begin
      state_next.sdaFilt = '{sync: FILT_RST, level: 1'b1, count: SPIKE_CNT_RST};
      state_next.sclFilt = '{sync: FILT_RST, level: 1'b1, count: SPIKE_CNT_RST};
    end else begin
      state_next.sdaFilt = filtStep(state_reg.sdaFilt, portCPadIn[PC_SDA]);
      state_next.sclFilt = filtStep(state_reg.sclFilt, portCPadIn[PC_SCL]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{rstSync: SYNC_RST,
                     sdaFilt: '{sync: FILT_RST, level: 1'b1, count: SPIKE_CNT_RST},
                     sclFilt: '{sync: FILT_RST, level: 1'b1, count: SPIKE_CNT_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// File: src/pbc_pkg.sv
/*
  Package for the port B/C alternate-function override block: pin indices,
  spike filter timing and the per-pin override carrier struct.
  Assumes a 100 MHz core clock.
*/
package pbc_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SPIKE_FILTER_NS = 50;
  // Pulses shorter than the filter time are removed: round the hold count up
  localparam int unsigned SPIKE_CYCLES    = (SPIKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  SPIKE_CNT_MAX   = 3'(SPIKE_CYCLES);
  localparam logic [2:0]  SPIKE_CNT_RST   = 3'h0;

  // Port B pin indices
  localparam int unsigned PB_SCK  = 7;
  localparam int unsigned PB_MISO = 6;
  localparam int unsigned PB_MOSI = 5;
  localparam int unsigned PB_SS   = 4;
  localparam int unsigned PB_OC0  = 3;
  localparam int unsigned PB_EXT_INTERRUPT_TWO = 2;
  localparam int unsigned PB_T1   = 1;
  localparam int unsigned PB_XCK  = 0;

  // Port C pin indices
  localparam int unsigned PC_OSC2 = 7;
  localparam int unsigned PC_OSC1 = 6;
  localparam int unsigned PC_TDI  = 5;
  localparam int unsigned PC_TDO  = 4;
  localparam int unsigned PC_TMS  = 3;
  localparam int unsigned PC_TCK  = 2;
  localparam int unsigned PC_SDA  = 1;
  localparam int unsigned PC_SCL  = 0;

  localparam logic [1:0] SYNC_RST   = 2'h0;
  localparam logic [1:0] FILT_RST   = 2'h3;

  // Override enable/value pairs for one 8-bit port
  typedef struct packed {
    logic [7:0] pullupOverrideEnable;
    logic [7:0] pullupOverrideValue;
    logic [7:0] directionOverrideEnable;
    logic [7:0] directionOverrideValue;
    logic [7:0] outputOverrideEnable;
    logic [7:0] outputOverrideValue;
    logic [7:0] inputEnableOverrideEnable;
    logic [7:0] inputEnableOverrideValue;
  } pbc_override_s;

  // Ordinary port register view of one port
  typedef struct packed {
    logic [7:0] portOut;
    logic [7:0] portDir;
  } pbc_portregs_s;

  // Resolved pad controls of one port
  typedef struct packed {
    logic [7:0] pullupOn;
    logic [7:0] outEnable;
    logic [7:0] outValue;
    logic [7:0] inputEnable;
  } pbc_pad_s;

  // Two-wire spike filter state for one line
  typedef struct packed {
    logic [1:0] sync;
    logic       level;
    logic [2:0] count;
  } pbc_filt_s;

  typedef struct packed {
    logic [1:0] rstSync;
    pbc_filt_s  sdaFilt;
    pbc_filt_s  sclFilt;
  } pbc_state_s;

endpackage
